// ### design/rf_switch_defs.svh
// timing, field and reset constants for the rf switch control port
`ifndef RF_SWITCH_DEFS_SVH
`define RF_SWITCH_DEFS_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define FRAME_BITS 16
`define FRAME_MSB 15
`define CHANNELS 4
`define CTRL_RESET 8'h00
`define STATE_RESET 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ 25.0
`define POR_TIME_MS 2.5
`define STARTUP_TIME_MS 33.0
`define TOGGLE_LOW_NS 500.0
// longest times round down, least times round up
`define POR_CYCLES ($rtoi(`POR_TIME_MS * `CLK_MHZ * 1000.0))
`define STARTUP_CYCLES ($rtoi(`STARTUP_TIME_MS * `CLK_MHZ * 1000.0))
`define TOGGLE_LOW_CYCLES ($rtoi($ceil(`TOGGLE_LOW_NS * `CLK_MHZ / 1000.0)))
`define COUNT_W 20

`endif

// ### design/rf_switch_pkg.sv
// types shared by the rf switch control port
package rf_switch_pkg;

    // control byte, bit 7 down to bit 0
    typedef struct packed {
        logic write_enable;
        logic fault_status;
        logic sleep;
        logic fault_mode_off;
        logic vpp_comp_off;
        logic spare_2;
        logic pump_enable_bit;
        logic spare_0;
    } ctrl_reg_t;

    typedef struct packed {
        ctrl_reg_t ctrl;
        logic [7:0] state;
    } frame_t;

    // synchronised pin levels
    typedef struct packed {
        logic mode_strap;
        logic flip_select;
        logic fault_select;
        logic pump_pin;
        logic fault_detect;
        logic rail_good;
        logic cs_n;
        logic [3:0] channel;
    } pin_sample_t;

    typedef enum logic [3:0] {
        ST_POR = 4'b0001,
        ST_RUN = 4'b0010,
        ST_SHUTDOWN = 4'b0100,
        ST_SHUT_LOW = 4'b1000
    } core_state_t;

endpackage

// ### design/sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // core clock
    input wire logic reset, // synchronous, active high
    input wire logic [WIDTH-1:0] async_in, // levels from another domain
    output logic [WIDTH-1:0] sync_out // synchronised levels
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    initial
    begin
        if (WIDTH < 1)
            $error("sync2 width must be at least one");
    end

    // first stage feeds only the second
    always_comb
    begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule

// ### design/spi_shift_link.sv
// serial shifter running on the host clock
`timescale 1ns/10ps
`include "rf_switch_defs.svh"
module spi_shift_link (
    input wire logic sck, // host serial clock
    input wire logic chip_select_n, // frame select, low active
    input wire logic mosi, // serial data in
    input wire rf_switch_pkg::frame_t load_word, // stored data sent out
    output rf_switch_pkg::frame_t rx_word, // last 16 bits received
    output logic miso // serial data out
);
    logic first_reg;
    logic first_next;
    logic [`FRAME_MSB:0] shift_reg;
    logic [`FRAME_MSB:0] shift_next;
    logic out_reg;
    logic out_next;

    // first edge of a frame pulls the stored word in, later edges shift
    always_comb
    begin
        first_next = 1'b0;
        if (first_reg)
            shift_next = {load_word[`FRAME_MSB-1:0], mosi};
        else
            shift_next = {shift_reg[`FRAME_MSB-1:0], mosi};
        out_next = shift_reg[`FRAME_MSB];
    end

    // sck stands still between frames, so the frame select ends the frame
    always_ff @(posedge sck or posedge chip_select_n)
    begin
        if (chip_select_n)
            first_reg <= 1'b1;
        else
            first_reg <= first_next;
    end

    // rising edge samples data in, msb first
    always_ff @(posedge sck)
    begin
        shift_reg <= shift_next;
    end

    // falling edge presents the next bit
    always_ff @(negedge sck or posedge chip_select_n)
    begin
        if (chip_select_n)
            out_reg <= 1'b0;
        else
            out_reg <= out_next;
    end

    // msb is visible as soon as the frame opens
    assign miso = first_reg ? load_word[`FRAME_MSB] : out_reg;
    assign rx_word = shift_reg;
endmodule

// ### design/rf_switch_driver_control_port.sv
// control front end of an rf switch driver: serial or parallel control
`timescale 1ns/10ps
`include "rf_switch_defs.svh"
module rf_switch_driver_control_port #(
    parameter int POR_CYCLES = `POR_CYCLES,
    parameter int STARTUP_CYCLES = `STARTUP_CYCLES
) (
    input wire logic clk, // core clock, 25 MHz
    input wire logic reset, // synchronous, active high
    input wire logic mode_strap, // low serial, high parallel
    input wire logic sck_channel_in_1, // serial clock or channel input 1
    input wire logic mosi_channel_in_2, // serial data in or channel input 2
    input wire logic miso_channel_in_3_i, // pin level, channel input 3
    output logic miso_channel_in_3_o, // serial data out
    output logic miso_channel_in_3_oe, // high while driving serial data
    input wire logic chip_select_n, // select low or channel input 4
    input wire logic flip_select, // parallel mode, high opens all channels
    input wire logic fault_shutdown_select, // parallel fault mode pin
    input wire logic pump_enable_pin, // parallel pump enable pin
    input wire logic fault_detect, // supply comparators, high on fault
    input wire logic hv_rail_good, // rail above ninety percent
    output logic [3:0] switch_channel, // high closes channel
    output logic pump_run, // charge pump running
    output logic vpp_comp_enable, // rail comparator active
    output logic sleep_active, // analog sleep request
    output logic fault_out_n_o, // fault pin level when driven
    output logic fault_out_n_oe, // high while pulling fault low
    output logic cs_pull_up_en, // select pin pull-up on
    output logic cs_pull_down_en, // select pin pull-down on
    output logic input_pull_down_en, // pull-downs on other inputs
    output logic inputs_valid, // power-on wait over
    output logic serial_mode, // latched interface mode
    output logic pump_startup_late // rail missed its start-up time
);
    localparam int TOGGLE_CYCLES = `TOGGLE_LOW_CYCLES;
    localparam logic [`COUNT_W-1:0] POR_LAST = `COUNT_W'(POR_CYCLES - 1);
    localparam logic [`COUNT_W-1:0] STARTUP_LAST = `COUNT_W'(STARTUP_CYCLES - 1);
    localparam logic [`COUNT_W-1:0] TOGGLE_LAST = `COUNT_W'(TOGGLE_CYCLES - 1);

    initial
    begin
        if (POR_CYCLES < 1 || POR_CYCLES > (1 << `COUNT_W))
            $error("power-on count out of range");
        if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > (1 << `COUNT_W))
            $error("start-up count out of range");
    end

    // ----------------------------------------------------------------
    // pin synchronisers and serial link
    // ----------------------------------------------------------------
    rf_switch_pkg::pin_sample_t pin_raw;
    rf_switch_pkg::pin_sample_t pin_s;
    rf_switch_pkg::frame_t rx_word;
    rf_switch_pkg::frame_t frame_out_reg;
    rf_switch_pkg::frame_t frame_out_next;
    logic link_miso;

    // shared pins also serve as parallel channel inputs
    always_comb
    begin
        pin_raw.mode_strap = mode_strap;
        pin_raw.flip_select = flip_select;
        pin_raw.fault_select = fault_shutdown_select;
        pin_raw.pump_pin = pump_enable_pin;
        pin_raw.fault_detect = fault_detect;
        pin_raw.rail_good = hv_rail_good;
        pin_raw.cs_n = chip_select_n;
        pin_raw.channel = {chip_select_n, miso_channel_in_3_i,
                           mosi_channel_in_2, sck_channel_in_1};
    end

    sync2 #(
        .WIDTH($bits(rf_switch_pkg::pin_sample_t))
    ) u_pin_sync (
        .clk(clk),
        .reset(reset),
        .async_in(pin_raw),
        .sync_out(pin_s)
    );

    spi_shift_link u_link (
        .sck(sck_channel_in_1),
        .chip_select_n(chip_select_n),
        .mosi(mosi_channel_in_2),
        .load_word(frame_out_reg),
        .rx_word(rx_word),
        .miso(link_miso)
    );

    // ----------------------------------------------------------------
    // core state
    // ----------------------------------------------------------------
    rf_switch_pkg::core_state_t state_reg, state_next;
    rf_switch_pkg::ctrl_reg_t ctrl_reg, ctrl_next;
    logic [7:0] chan_reg, chan_next;
    logic [`COUNT_W-1:0] por_count_reg, por_count_next;
    logic [`COUNT_W-1:0] low_count_reg, low_count_next;
    logic [`COUNT_W-1:0] start_count_reg, start_count_next;
    logic serial_reg, serial_next;
    logic cs_prev_reg, cs_prev_next;
    logic cs_rise, pump_src, shutdown_en, fault_now;

    // the effective pump and fault-mode sources depend on the mode
    always_comb
    begin
        cs_rise = pin_s.cs_n & ~cs_prev_reg;
        fault_now = pin_s.fault_detect & (state_reg != rf_switch_pkg::ST_POR);
        if (serial_reg)
        begin
            pump_src = ctrl_reg.pump_enable_bit;
            shutdown_en = ~ctrl_reg.fault_mode_off;
        end
        else
        begin
            pump_src = pin_s.pump_pin;
            shutdown_en = ~pin_s.fault_select;
        end
    end

    // sequencing: power-on wait, run, fault shutdown and restart
    always_comb
    begin
        state_next = state_reg;
        por_count_next = por_count_reg;
        low_count_next = low_count_reg;
        serial_next = serial_reg;
        unique case (state_reg)
            rf_switch_pkg::ST_POR:
            begin
                // strap is caught once, when the wait ends
                if (por_count_reg == POR_LAST)
                begin
                    state_next = rf_switch_pkg::ST_RUN;
                    serial_next = ~pin_s.mode_strap;
                end
                else
                    por_count_next = por_count_reg + 1'b1;
            end
            rf_switch_pkg::ST_RUN:
            begin
                if (fault_now && shutdown_en)
                    state_next = rf_switch_pkg::ST_SHUTDOWN;
            end
            rf_switch_pkg::ST_SHUTDOWN:
            begin
                low_count_next = '0;
                if (!pump_src)
                    state_next = rf_switch_pkg::ST_SHUT_LOW;
            end
            rf_switch_pkg::ST_SHUT_LOW:
            begin
                // a low pulse that is too short does not restart
                if (pump_src)
                begin
                    if (low_count_reg >= TOGGLE_LAST)
                        state_next = rf_switch_pkg::ST_RUN;
                    else
                        state_next = rf_switch_pkg::ST_SHUTDOWN;
                end
                else if (low_count_reg != TOGGLE_LAST)
                    low_count_next = low_count_reg + 1'b1;
            end
        endcase
    end

    // stored registers; fault status set wins over a clearing write
    always_comb
    begin
        cs_prev_next = pin_s.cs_n;
        ctrl_next = ctrl_reg;
        chan_next = chan_reg;
        if (serial_reg && cs_rise && state_reg != rf_switch_pkg::ST_POR
            && rx_word.ctrl.write_enable)
        begin
            ctrl_next = rx_word.ctrl;
            ctrl_next.fault_status = ctrl_reg.fault_status & rx_word.ctrl.fault_status;
            chan_next = rx_word.state;
        end
        ctrl_next.write_enable = 1'b0;
        if (fault_now)
            ctrl_next.fault_status = 1'b1;
        // read word only moves while the frame is closed
        frame_out_next = frame_out_reg;
        if (pin_s.cs_n)
        begin
            frame_out_next.ctrl = ctrl_reg;
            frame_out_next.state = chan_reg;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= rf_switch_pkg::ST_POR;
            por_count_reg <= '0;
            low_count_reg <= '0;
            serial_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
            ctrl_reg <= `CTRL_RESET;
            chan_reg <= `STATE_RESET;
            frame_out_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            por_count_reg <= por_count_next;
            low_count_reg <= low_count_next;
            serial_reg <= serial_next;
            cs_prev_reg <= cs_prev_next;
            ctrl_reg <= ctrl_next;
            chan_reg <= chan_next;
            frame_out_reg <= frame_out_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs and start-up watch
    // ----------------------------------------------------------------
    logic [3:0] switch_reg, switch_next;
    logic pump_reg, pump_next;
    logic vpp_reg, vpp_next;
    logic sleep_reg, sleep_next;
    logic fault_oe_reg, fault_oe_next;
    logic pull_up_reg, pull_up_next;
    logic late_reg, late_next;
    logic valid_reg, valid_next;

    // channels and pump follow mode; any stop state opens everything
    always_comb
    begin
        valid_next = (state_reg != rf_switch_pkg::ST_POR);
        switch_next = '0;
        if (state_reg == rf_switch_pkg::ST_RUN)
        begin
            if (serial_reg)
                switch_next = chan_reg[3:0];
            else if (!pin_s.flip_select)
                switch_next = pin_s.channel;
        end
        sleep_next = serial_reg & ctrl_reg.sleep & valid_next;
        pump_next = (state_reg == rf_switch_pkg::ST_RUN) & pump_src & ~sleep_next;
        vpp_next = pump_next & (serial_reg ? ~ctrl_reg.vpp_comp_off : 1'b1);
        fault_oe_next = fault_now;
        // before the strap is caught, the pull follows its live level
        pull_up_next = valid_next ? serial_reg : ~pin_s.mode_strap;
    end

    // time the rail rise from each pump start
    always_comb
    begin
        start_count_next = start_count_reg;
        late_next = late_reg;
        if (!pump_reg)
        begin
            start_count_next = '0;
            late_next = 1'b0;
        end
        else if (!pin_s.rail_good)
        begin
            if (start_count_reg == STARTUP_LAST)
                late_next = 1'b1;
            else
                start_count_next = start_count_reg + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            switch_reg <= '0;
            pump_reg <= 1'b0;
            vpp_reg <= 1'b0;
            sleep_reg <= 1'b0;
            fault_oe_reg <= 1'b0;
            pull_up_reg <= 1'b1;
            late_reg <= 1'b0;
            valid_reg <= 1'b0;
            start_count_reg <= '0;
        end
        else
        begin
            switch_reg <= switch_next;
            pump_reg <= pump_next;
            vpp_reg <= vpp_next;
            sleep_reg <= sleep_next;
            fault_oe_reg <= fault_oe_next;
            pull_up_reg <= pull_up_next;
            late_reg <= late_next;
            valid_reg <= valid_next;
            start_count_reg <= start_count_next;
        end
    end

    // data out is driven only in serial mode with the frame open
    assign miso_channel_in_3_o = link_miso;
    assign miso_channel_in_3_oe = serial_reg & valid_reg & ~chip_select_n;
    assign switch_channel = switch_reg;
    assign pump_run = pump_reg;
    assign vpp_comp_enable = vpp_reg;
    assign sleep_active = sleep_reg;
    assign fault_out_n_o = 1'b0;
    assign fault_out_n_oe = fault_oe_reg;
    assign cs_pull_up_en = pull_up_reg;
    assign cs_pull_down_en = ~pull_up_reg;
    assign input_pull_down_en = 1'b1;
    assign inputs_valid = valid_reg;
    assign serial_mode = serial_reg;
    assign pump_startup_late = late_reg;
endmodule

// ### bench/spi_host_model.sv
// host model: serial master and parallel level driver
`timescale 1ns/10ps
module spi_host_model (
    output logic sck, // link clock, still between frames
    output logic mosi, // serial data into the device
    output logic cs_n, // frame select, low active
    output logic ch3, // channel 3 level, low when released
    input wire logic miso // serial data out of the device
);
    // idle: deselected, released lines at their pull levels
    initial
    begin
        sck = 1'b0;
        mosi = 1'b0;
        cs_n = 1'b1;
        ch3 = 1'b0;
    end
    // n bits msb first at a 30 ns link period, collecting what comes back
    task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0000_0000;
        cs_n = 1'b0;
        #130;
        for (int i = n - 1; i >= 0; i--)
        begin
            mosi = tx[i];
            #15 sck = 1'b1;
            rx = {rx[30:0], miso};
            #15 sck = 1'b0;
        end
        #20 cs_n = 1'b1;
        mosi = 1'b0; // released line falls to its pull-down
        #200;
    endtask
    // parallel mode: the four shared pins carry channel levels
    task automatic par(input logic [3:0] ch);
        sck = ch[0];
        mosi = ch[1];
        ch3 = ch[2];
        cs_n = ch[3];
    endtask
endmodule

// ### bench/rf_port_assertions.sv
// concurrent checks on the rf switch control port pins
`timescale 1ns/10ps
module rf_port_checker #(
    parameter int POR_CYCLES = 20,
    parameter int STARTUP_CYCLES = 50
) (
    input wire logic clk, // core clock
    input wire logic reset, // sync reset
    input wire logic sck_channel_in_1, // pin 1
    input wire logic mosi_channel_in_2, // pin 2
    input wire logic miso_channel_in_3_i, // pin 3
    input wire logic miso_channel_in_3_oe, // serial drive
    input wire logic chip_select_n, // pin 4
    input wire logic flip_select, // flip pin
    input wire logic pump_enable_pin, // pump pin
    input wire logic fault_detect, // fault in
    input wire logic hv_rail_good, // rail ok
    input wire logic [3:0] switch_channel, // channels
    input wire logic pump_run, // pump
    input wire logic fault_out_n_oe, // fault drive
    input wire logic cs_pull_up_en, // pull-up
    input wire logic cs_pull_down_en, // pull-down
    input wire logic inputs_valid, // wait over
    input wire logic serial_mode, // mode
    input wire logic pump_startup_late // late
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    logic [3:0] pins;
    logic [19:0] por_cnt, por_next, late_cnt, late_next;
    assign pins = {chip_select_n, miso_channel_in_3_i, mosi_channel_in_2, sck_channel_in_1};
    // ----------------------------------------------------------------
    // helper counters, saturating so a long run cannot wrap them
    // ----------------------------------------------------------------
    always_comb
    begin
        por_next = (por_cnt == 20'hF_FFFF) ? por_cnt : por_cnt + 20'h0_0001;
        late_next = 20'h0_0000;
        if (pump_run && !hv_rail_good)
            late_next = (late_cnt < 20'(STARTUP_CYCLES + 4)) ? late_cnt + 20'h0_0001 : late_cnt;
    end
    always_ff @(posedge clk)
    begin
        por_cnt <= reset ? 20'h0_0000 : por_next;
        late_cnt <= reset ? 20'h0_0000 : late_next;
    end
    property p_oe;
        miso_channel_in_3_oe == (serial_mode && inputs_valid && !chip_select_n);
    endproperty
    a_oe: assert property (p_oe) else $error("serial out drive wrong");
    property p_fault;
        inputs_valid && $rose(fault_detect) |-> ##[1:4] fault_out_n_oe;
    endproperty
    a_fault: assert property (p_fault) else $error("fault pin not pulled");
    // margin of four stable cycles covers the two synchroniser stages
    property p_follow;
        (!serial_mode && inputs_valid && pump_run && !flip_select && !fault_detect
            && $stable(pins))[*4] |-> switch_channel == pins;
    endproperty
    a_follow: assert property (p_follow) else $error("channels miss pins");
    property p_pump_pin;
        (!serial_mode && inputs_valid && !pump_enable_pin)[*4] |-> !pump_run;
    endproperty
    a_pump_pin: assert property (p_pump_pin) else $error("pump runs pin low");
    property p_pulls;
        inputs_valid |-> cs_pull_up_en == serial_mode && cs_pull_down_en == !serial_mode;
    endproperty
    a_pulls: assert property (p_pulls) else $error("select pull wrong");
    property p_mode;
        inputs_valid && $past(inputs_valid) |-> $stable(serial_mode);
    endproperty
    a_mode: assert property (p_mode) else $error("mode changed");
    property p_por;
        $rose(inputs_valid) |-> por_cnt >= 20'(POR_CYCLES - 1) && por_cnt <= 20'(POR_CYCLES + 2);
    endproperty
    a_por: assert property (p_por) else $error("power-on wait length wrong");
    property p_late;
        late_cnt == 20'(STARTUP_CYCLES + 4) |-> pump_startup_late;
    endproperty
    a_late: assert property (p_late) else $error("late rail not flagged");
    cover property ($rose(fault_out_n_oe));
    cover property ($rose(pump_startup_late));
    cover property (!serial_mode && inputs_valid && switch_channel == 4'hf);
endmodule
bind rf_switch_driver_control_port rf_port_checker #(.POR_CYCLES(POR_CYCLES),
    .STARTUP_CYCLES(STARTUP_CYCLES)) port_chk (.clk(clk), .reset(reset),
    .sck_channel_in_1(sck_channel_in_1), .mosi_channel_in_2(mosi_channel_in_2),
    .miso_channel_in_3_i(miso_channel_in_3_i), .miso_channel_in_3_oe(miso_channel_in_3_oe),
    .chip_select_n(chip_select_n), .flip_select(flip_select),
    .pump_enable_pin(pump_enable_pin), .fault_detect(fault_detect),
    .hv_rail_good(hv_rail_good), .switch_channel(switch_channel), .pump_run(pump_run),
    .fault_out_n_oe(fault_out_n_oe), .cs_pull_up_en(cs_pull_up_en),
    .cs_pull_down_en(cs_pull_down_en), .inputs_valid(inputs_valid),
    .serial_mode(serial_mode), .pump_startup_late(pump_startup_late));

// ### bench/testbench.sv
// self-checking bench for the rf switch control port
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic strap = 1'b0;
    logic flip = 1'b1;
    logic fsel = 1'b1;
    logic ppin = 1'b0;
    logic fdet = 1'b0;
    logic rail = 1'b0;
    logic sck, mosi, csn, ch3, pin3, so, soe, prun, vpp, slp, fo, foe;
    logic pu, pd, ipd, valid, smode, late;
    logic [3:0] sw;
    logic [31:0] rx;
    int err_count = 0;
    int checks = 0;
    int cyc_n = 0;
    // short waits so the run stays small
    rf_switch_driver_control_port #(.POR_CYCLES(20), .STARTUP_CYCLES(50)) DUT (
        .clk(clk), .reset(reset), .mode_strap(strap), .sck_channel_in_1(sck),
        .mosi_channel_in_2(mosi), .miso_channel_in_3_i(pin3), .miso_channel_in_3_o(so),
        .miso_channel_in_3_oe(soe), .chip_select_n(csn), .flip_select(flip),
        .fault_shutdown_select(fsel), .pump_enable_pin(ppin), .fault_detect(fdet),
        .hv_rail_good(rail), .switch_channel(sw), .pump_run(prun), .vpp_comp_enable(vpp),
        .sleep_active(slp), .fault_out_n_o(fo), .fault_out_n_oe(foe), .cs_pull_up_en(pu),
        .cs_pull_down_en(pd), .input_pull_down_en(ipd), .inputs_valid(valid),
        .serial_mode(smode), .pump_startup_late(late));
    spi_host_model host (.sck(sck), .mosi(mosi), .cs_n(csn), .ch3(ch3), .miso(pin3));
    assign pin3 = soe ? so : ch3; // device drives, else host level
    always #20 clk = ~clk;
    // hang guard; the tests need well under 3000 cycles
    always @(posedge clk)
    begin
        cyc_n++;
        if (cyc_n == 5000)
        begin
            err_count++;
            end_of_test;
        end
    end
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] tx, input int n);
        host.frame(tx, n, rx);
        cyc(6);
    endtask
    task automatic pwr(input logic s);
        reset = 1'b1;
        strap = s;
        cyc(4);
        reset = 1'b0;
        for (int i = 0; i < 40 && valid !== 1'b1; i++)
            cyc(1);
        chk("valid", 1'b1, valid);
    endtask
    task automatic end_of_test;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // serial pass with pins held opposite, then a parallel pass
    initial
    begin
        pwr(1'b0);
        chk("pulls", 4'hd, {smode, pu, pd, ipd});
        wr(32'h0000_820A, 16);
        chk("channels", 4'hA, sw);
        chk("pump", 3'b110, {prun, vpp, slp});
        wr(32'h0000_0005, 16);
        chk("readback", 16'h020A, rx[15:0]);
        chk("no write", 4'hA, sw);
        wr(32'h1234_8209, 32);
        chk("chain out", 32'h020A_1234, rx);
        chk("chain state", 4'h9, sw);
        chk("late", 1'b1, late);
        rail = 1'b1;
        fdet = 1'b1;
        cyc(6);
        chk("shutdown", 7'h40, {foe, fo, prun, sw});
        wr(32'h0000_0000, 16);
        chk("status", 1'b1, rx[14]);
        fdet = 1'b0;
        wr(32'h0000_8009, 16);
        wr(32'h0000_8209, 16);
        chk("restart", 5'h19, {prun, sw});
        // sleep stops the pump; fault mode off keeps channels through a fault
        wr(32'h0000_AA09, 16);
        chk("sleep", 3'b001, {prun, vpp, slp});
        wr(32'h0000_9209, 16);
        fdet = 1'b1;
        cyc(6);
        chk("serial no shutdown", 6'h39, {foe, prun, sw});
        fdet = 1'b0;
        flip = 1'b0;
        ppin = 1'b1;
        pwr(1'b1);
        chk("pulls", 3'b001, {smode, pu, pd});
        for (int c = 0; c < 16; c++)
        begin
            host.par(c[3:0]);
            cyc(5);
            chk("parallel", c[3:0], sw);
        end
        flip = 1'b1;
        cyc(4);
        chk("flipped", 4'h0, sw);
        flip = 1'b0;
        ppin = 1'b0;
        cyc(5);
        chk("pump off", 1'b0, prun);
        ppin = 1'b1;
        fdet = 1'b1;
        cyc(6);
        chk("no shutdown", 7'h5F, {foe, fo, prun, sw});
        fdet = 1'b0;
        fsel = 1'b0;
        cyc(6);
        fdet = 1'b1;
        cyc(6);
        chk("shutdown", 5'h00, {prun, sw});
        fdet = 1'b0;
        ppin = 1'b0;
        cyc(5);
        ppin = 1'b1;
        cyc(6);
        chk("short low", 5'h00, {prun, sw});
        ppin = 1'b0;
        cyc(16);
        ppin = 1'b1;
        cyc(6);
        chk("restart", 5'h1F, {prun, sw});
        end_of_test;
    end
endmodule
